// [mpf_defines.svh]
`ifndef MPF_DEFINES_SVH
`define MPF_DEFINES_SVH

`define MPF_NPORT 8
`define MPF_PORT_W 3
`define MPF_DATA_W 64
`define MPF_BE_W 8
`define MPF_HALF_BE 4
`define MPF_RX_DEPTH 4
// receive entry layout
`define MPF_E_BE_LO 64
`define MPF_E_BE_HI 71
`define MPF_E_SOP 72
`define MPF_E_EOP 73
`define MPF_E_STAT 74
`define MPF_E_W 75
// transmit buffer word layout: entry plus port number
`define MPF_T_PORT_LO 75
`define MPF_T_PORT_HI 77
`define MPF_T_W 78
// byte enables, low active
`define MPF_BE_NONE 8'hff
`define MPF_BE_UPPER_OFF 8'hf0

`endif

// [mpf_pkg.sv]
package mpf_pkg;
    typedef enum logic [1:0] {
        MPF_BUS_IDLE,
        MPF_BUS_WRITE,
        MPF_BUS_READ,
        MPF_BUS_ABORT
    } mpf_bus_op_type;
endpackage

// [mpf_skid_buf.sv]
`timescale 1ns/1ps
// two-entry buffer; a stalled drain never drops an accepted word
module mpf_skid_buf #(
    parameter int WIDTH = 78
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic rd_q;
    logic wr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    fill_bound_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cnt_q == 2'h2 && !out_ready_i |=> cnt_q == 2'h2 && !in_ready_o)
        else $error("buffer lost its contents while stalled");
endmodule

// [mpf_fifo_bus.sv]
`timescale 1ns/1ps
`include "mpf_defines.svh"
module mpf_fifo_bus #(
    parameter int RX_DEPTH = `MPF_RX_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic bus32_i,
    input wire logic txsel_n_i,
    input wire logic rxsel_n_i,
    input wire logic [`MPF_PORT_W-1:0] port_sel_i,
    input wire logic [`MPF_DATA_W-1:0] data_i,
    output logic [`MPF_DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [`MPF_BE_W-1:0] be_n_i,
    output logic [`MPF_BE_W-1:0] be_n_o,
    output logic be_oe_o,
    input wire logic sop_i,
    output logic sop_o,
    output logic sop_oe_o,
    input wire logic eop_i,
    output logic eop_o,
    output logic eop_oe_o,
    input wire logic rx_keep_i,
    input wire logic rx_abort_i,
    output logic tx_wr_ready_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [`MPF_PORT_W-1:0] tx_port_o,
    output logic [`MPF_DATA_W-1:0] tx_data_o,
    output logic [`MPF_BE_W-1:0] tx_be_n_o,
    output logic tx_sop_o,
    output logic tx_eop_o,
    input wire logic rx_wr_valid_i,
    output logic rx_wr_ready_o,
    input wire logic [`MPF_PORT_W-1:0] rx_wr_port_i,
    input wire logic [`MPF_DATA_W-1:0] rx_wr_data_i,
    input wire logic [`MPF_BE_W-1:0] rx_wr_be_n_i,
    input wire logic rx_wr_sop_i,
    input wire logic rx_wr_eop_i,
    input wire logic rx_wr_status_i
);
    localparam int PW = $clog2(RX_DEPTH);
    localparam int CW = PW + 1;
    localparam int SW = `MPF_PORT_W + `MPF_DATA_W + `MPF_BE_W + 7;

    logic [SW-1:0] pin_s1_q;
    logic [SW-1:0] pin_s2_q;
    logic s_bus32;
    logic s_txsel_n;
    logic s_rxsel_n;
    logic [`MPF_PORT_W-1:0] s_port;
    logic [`MPF_DATA_W-1:0] s_data;
    logic [`MPF_BE_W-1:0] s_be_n;
    logic s_sop;
    logic s_eop;
    logic s_keep;
    logic s_abort;
    mpf_pkg::mpf_bus_op_type op;

    logic [`MPF_E_W-1:0] mem_q [`MPF_NPORT*RX_DEPTH];
    logic [PW-1:0] rp_q [`MPF_NPORT];
    logic [PW-1:0] wp_q [`MPF_NPORT];
    logic [CW-1:0] cnt_q [`MPF_NPORT];
    logic [`MPF_NPORT-1:0] flush_q;
    logic [`MPF_NPORT-1:0] pop_v;
    logic [`MPF_NPORT-1:0] flush_done_v;
    logic [`MPF_E_W-1:0] head;
    logic rd_pop;
    logic rx_push;
    logic tx_in_valid;
    logic [`MPF_T_W-1:0] tx_in_word;
    logic [`MPF_T_W-1:0] tx_out_word;

    function automatic int unsigned slot(input logic [`MPF_PORT_W-1:0] p,
                                         input logic [PW-1:0] i);
        slot = int'(p) * RX_DEPTH + int'(i);
    endfunction

    // in 32-bit mode the upper lanes never count as valid
    function automatic logic [`MPF_BE_W-1:0] lane_mask(input logic [`MPF_BE_W-1:0] be_n,
                                                      input logic narrow);
        lane_mask = narrow ? (be_n | `MPF_BE_UPPER_OFF) : be_n;
    endfunction

    // pins come from outside logic, so two flops before any use
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
        end else begin
            pin_s1_q <= {bus32_i, txsel_n_i, rxsel_n_i, port_sel_i, data_i, be_n_i,
                         sop_i, eop_i, rx_keep_i, rx_abort_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign {s_bus32, s_txsel_n, s_rxsel_n, s_port, s_data, s_be_n,
            s_sop, s_eop, s_keep, s_abort} = pin_s2_q;

    // selects are low active; both low is illegal and moves nothing
    always_comb begin
        if (!s_txsel_n && !s_rxsel_n) begin
            op = mpf_pkg::MPF_BUS_IDLE;
        end else if (!s_txsel_n) begin
            op = mpf_pkg::MPF_BUS_WRITE;
        end else if (!s_rxsel_n && s_abort) begin
            op = mpf_pkg::MPF_BUS_ABORT;
        end else if (!s_rxsel_n) begin
            op = mpf_pkg::MPF_BUS_READ;
        end else begin
            op = mpf_pkg::MPF_BUS_IDLE;
        end
    end

    // transmit path: one word per write cycle into the two-entry buffer
    assign tx_in_valid = (op == mpf_pkg::MPF_BUS_WRITE);
    assign tx_in_word = {s_port, 1'b0, s_eop, s_sop, lane_mask(s_be_n, s_bus32),
                         s_data};

    mpf_skid_buf #(
        .WIDTH(`MPF_T_W)
    ) u_tx_buf (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(tx_in_valid),
        .in_ready_o(tx_wr_ready_o),
        .in_data_i(tx_in_word),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_out_word)
    );

    assign tx_port_o = tx_out_word[`MPF_T_PORT_HI:`MPF_T_PORT_LO];
    assign tx_data_o = tx_out_word[`MPF_DATA_W-1:0];
    assign tx_be_n_o = tx_out_word[`MPF_E_BE_HI:`MPF_E_BE_LO];
    assign tx_sop_o = tx_out_word[`MPF_E_SOP];
    assign tx_eop_o = tx_out_word[`MPF_E_EOP];

    // receive path
    assign head = mem_q[slot(s_port, rp_q[s_port])];
    // keep leaves the head in place so the same word is read again
    assign rd_pop = (op == mpf_pkg::MPF_BUS_READ) && !s_keep
                    && (cnt_q[s_port] != '0) && !flush_q[s_port];
    assign rx_wr_ready_o = (cnt_q[rx_wr_port_i] != CW'(RX_DEPTH));
    assign rx_push = rx_wr_valid_i && rx_wr_ready_o;

    // a flushing port drops one entry a cycle up to and including its status word
    always_comb begin
        pop_v = '0;
        flush_done_v = '0;
        for (int p = 0; p < `MPF_NPORT; p++) begin
            if (flush_q[p] && cnt_q[p] != '0) begin
                pop_v[p] = 1'b1;
                flush_done_v[p] = mem_q[slot(`MPF_PORT_W'(p), rp_q[p])][`MPF_E_STAT];
            end
        end
        if (rd_pop) begin
            pop_v[s_port] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rx_push) begin
            mem_q[slot(rx_wr_port_i, wp_q[rx_wr_port_i])] <=
                {rx_wr_status_i, rx_wr_eop_i, rx_wr_sop_i, rx_wr_be_n_i, rx_wr_data_i};
        end
    end

    // reset empties every port
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            for (int p = 0; p < `MPF_NPORT; p++) begin
                rp_q[p] <= '0;
                wp_q[p] <= '0;
                cnt_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < `MPF_NPORT; p++) begin
                logic in_p;
                in_p = rx_push && (rx_wr_port_i == `MPF_PORT_W'(p));
                if (in_p) begin
                    wp_q[p] <= PW'(wp_q[p] + 1'b1);
                end
                if (pop_v[p]) begin
                    rp_q[p] <= PW'(rp_q[p] + 1'b1);
                end
                cnt_q[p] <= cnt_q[p] + CW'(in_p) - CW'(pop_v[p]);
            end
        end
    end

    // a fresh abort wins over the end of an older flush
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            flush_q <= '0;
        end else begin
            for (int p = 0; p < `MPF_NPORT; p++) begin
                if (op == mpf_pkg::MPF_BUS_ABORT && s_port == `MPF_PORT_W'(p)) begin
                    flush_q[p] <= 1'b1;
                end else if (flush_done_v[p]) begin
                    flush_q[p] <= 1'b0;
                end
            end
        end
    end

    // bus drivers: enabled only in the cycle after a sampled receive select
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= (op == mpf_pkg::MPF_BUS_READ || op == mpf_pkg::MPF_BUS_ABORT);
        end
    end

    assign be_oe_o = data_oe_o;
    assign sop_oe_o = data_oe_o;
    assign eop_oe_o = data_oe_o;

    // an empty or flushing port answers with no valid lanes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_o <= '0;
            be_n_o <= `MPF_BE_NONE;
            sop_o <= 1'b0;
            eop_o <= 1'b0;
        end else if (op == mpf_pkg::MPF_BUS_READ && cnt_q[s_port] != '0
                     && !flush_q[s_port]) begin
            data_o <= head[`MPF_DATA_W-1:0];
            be_n_o <= lane_mask(head[`MPF_E_BE_HI:`MPF_E_BE_LO], s_bus32);
            sop_o <= head[`MPF_E_SOP];
            eop_o <= head[`MPF_E_EOP];
        end else if (op == mpf_pkg::MPF_BUS_READ || op == mpf_pkg::MPF_BUS_ABORT) begin
            data_o <= '0;
            be_n_o <= `MPF_BE_NONE;
            sop_o <= 1'b0;
            eop_o <= 1'b0;
        end
    end

    rx_drive_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_rxsel_n |=> !data_oe_o && !be_oe_o && !sop_oe_o && !eop_oe_o)
        else $error("receive lines driven without receive select");

    tx_write_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tx_in_valid |-> !s_txsel_n && s_rxsel_n)
        else $error("transmit write without transmit select");

    rx_read_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_pop |-> !s_rxsel_n && s_txsel_n)
        else $error("receive pop without receive select");

    rx_keep_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !s_rxsel_n && s_keep && !s_abort && !rx_push |=> cnt_q[$past(s_port)] == $past(cnt_q[s_port]))
        else $error("kept word left the receive fifo");

    both_sel_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !s_txsel_n && !s_rxsel_n |=> !data_oe_o ##0 !$past(tx_in_valid))
        else $error("transfer made with both selects low");

    narrow_lanes_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $past(s_bus32) && data_oe_o |-> be_n_o[`MPF_BE_W-1:`MPF_HALF_BE] == '1)
        else $error("upper lanes marked valid in 32-bit mode");

    abort_flush_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        op == mpf_pkg::MPF_BUS_ABORT |=> flush_q[$past(s_port)] && data_oe_o)
        else $error("abort did not start a flush");

    read_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_pop |=> data_oe_o && be_n_o == lane_mask($past(head[`MPF_E_BE_HI:`MPF_E_BE_LO]), $past(s_bus32)))
        else $error("read word lanes do not match the stored entry");
endmodule

// [mpf_mac_model.sv]
`timescale 1ns/1ps
// mac side: drains the transmit stream with stalls and pushes receive entries
module mpf_mac_model (
    input wire logic clk_sys_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [2:0] tx_port_i,
    input wire logic [63:0] tx_data_i,
    input wire logic [7:0] tx_be_n_i,
    input wire logic tx_sop_i,
    input wire logic tx_eop_i,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [2:0] rx_port_o,
    output logic [63:0] rx_data_o,
    output logic [7:0] rx_be_n_o,
    output logic rx_sop_o,
    output logic rx_eop_o,
    output logic rx_status_o
);
    logic [1:0] stall_q = 2'h0;
    logic [76:0] seen[$];
    int stuck = 0;
    initial begin
        {rx_valid_o, rx_port_o, rx_data_o, rx_be_n_o, rx_sop_o, rx_eop_o, rx_status_o} = '0;
    end
    // stalls one cycle in four so the transmit buffer must hold words back
    assign tx_ready_o = (stall_q != 2'h3);
    always @(posedge clk_sys_i) begin
        stall_q <= stall_q + 2'h1;
        if (tx_valid_i && tx_ready_o) begin
            seen.push_back({tx_port_i, tx_sop_i, tx_eop_i, tx_be_n_i, tx_data_i});
        end
    end
    // a status entry is pushed right after the end word of a packet
    task automatic push(input logic [2:0] p, input logic [63:0] d, input logic [7:0] b,
                        input logic s, input logic e, input logic st);
        int n;
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b1;
        {rx_port_o, rx_data_o, rx_be_n_o, rx_sop_o, rx_eop_o, rx_status_o} <= {p, d, b, s, e, st};
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (rx_ready_i) break;
        end
        if (n == 20) stuck++;
        // released data and byte-enable lines show the inverse, never a stale copy of the word
        rx_valid_o <= 1'b0;
        rx_data_o <= ~d;
        rx_be_n_o <= ~b;
    endtask
endmodule

// [multiport_packet_fifo_bus_bench.sv]
`timescale 1ns/1ps
module multiport_packet_fifo_bus_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus32 = 1'b0, txsel_n = 1'b1, rxsel_n = 1'b1, sop = 1'b0, eop = 1'b0;
    logic keep = 1'b0, abort = 1'b0;
    logic [2:0] port_sel = 3'h0;
    logic [63:0] data = '1;
    logic [7:0] be_n = 8'hff;
    logic [63:0] data_o;
    logic [7:0] be_n_o;
    logic data_oe, be_oe, sop_o, sop_oe, eop_o, eop_oe, tx_wr_ready;
    logic tx_valid, tx_ready, tx_sop, tx_eop, rx_valid, rx_ready, rx_sop, rx_eop, rx_status;
    logic [2:0] tx_port, rx_port;
    logic [63:0] tx_data, rx_data;
    logic [7:0] tx_be_n, rx_be_n;
    int fails = 0;
    int total_checks = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    mpf_fifo_bus #(.RX_DEPTH(8)) mpf_fifo_bus_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .bus32_i(bus32), .txsel_n_i(txsel_n), .rxsel_n_i(rxsel_n), .port_sel_i(port_sel),
        .data_i(data), .data_o(data_o), .data_oe_o(data_oe), .be_n_i(be_n), .be_n_o(be_n_o),
        .be_oe_o(be_oe), .sop_i(sop), .sop_o(sop_o), .sop_oe_o(sop_oe), .eop_i(eop),
        .eop_o(eop_o), .eop_oe_o(eop_oe), .rx_keep_i(keep), .rx_abort_i(abort),
        .tx_wr_ready_o(tx_wr_ready), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_port_o(tx_port), .tx_data_o(tx_data), .tx_be_n_o(tx_be_n), .tx_sop_o(tx_sop),
        .tx_eop_o(tx_eop), .rx_wr_valid_i(rx_valid), .rx_wr_ready_o(rx_ready),
        .rx_wr_port_i(rx_port), .rx_wr_data_i(rx_data), .rx_wr_be_n_i(rx_be_n),
        .rx_wr_sop_i(rx_sop), .rx_wr_eop_i(rx_eop), .rx_wr_status_i(rx_status));

    mpf_mac_model mpf_mac_model_inst (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .tx_port_i(tx_port), .tx_data_i(tx_data), .tx_be_n_i(tx_be_n),
        .tx_sop_i(tx_sop), .tx_eop_i(tx_eop), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
        .rx_port_o(rx_port), .rx_data_o(rx_data), .rx_be_n_o(rx_be_n), .rx_sop_o(rx_sop),
        .rx_eop_o(rx_eop), .rx_status_o(rx_status));

    task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic pin(input logic tx, input logic rx, input logic [2:0] p, input logic [63:0] d,
                       input logic [7:0] b, input logic s, input logic e, input logic k,
                       input logic a);
        @(posedge clk_sys_i);
        {txsel_n, rxsel_n, port_sel, data, be_n, sop, eop, keep, abort} <= {tx, rx, p, d, b, s, e, k, a};
    endtask

    // released selects, data and byte enables float high as the pull-ups take them; sop, eop, keep and abort are driven low
    task automatic idle(input int n);
        repeat (n) pin(1'b1, 1'b1, 3'h0, '1, 8'hff, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [2:0] p, input logic k, input logic a, input logic [63:0] d,
                      input logic [7:0] b, input logic s, input logic e);
        pin(1'b1, 1'b0, p, '1, 8'hff, 1'b0, 1'b0, k, a);
        idle(1);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({data_oe, be_oe, sop_oe, eop_oe, data_o, be_n_o, sop_o, eop_o}, {4'hf, d, b, s, e}, "read word");
        @(posedge clk_sys_i);
        #1;
        chk({data_oe, be_oe, sop_oe, eop_oe}, 4'h0, "bus not released");
    endtask

    task automatic t_write;
        pin(1'b0, 1'b1, 3'h5, 64'h8877665544332211, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        pin(1'b0, 1'b1, 3'h5, 64'h00000000_0000a5c3, 8'hfc, 1'b0, 1'b1, 1'b0, 1'b0);
        pin(1'b0, 1'b0, 3'h5, 64'h1234, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
        idle(1);
        bus32 <= 1'b1;
        idle(4);
        pin(1'b0, 1'b1, 3'h0, 64'hffffffff_deadbeef, 8'hf0, 1'b1, 1'b1, 1'b0, 1'b0);
        pin(1'b0, 1'b1, 3'h7, 64'h00000000_0000abcd, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
        idle(12);
        bus32 <= 1'b0;
        chk(mpf_mac_model_inst.seen.size(), 4, "transmit word count");
        if (mpf_mac_model_inst.seen.size() == 4) begin
            chk(mpf_mac_model_inst.seen[0], {3'h5, 2'h2, 8'h00, 64'h8877665544332211}, "tx first");
            chk(mpf_mac_model_inst.seen[1], {3'h5, 2'h1, 8'hfc, 64'h0000a5c3}, "tx last");
            chk(mpf_mac_model_inst.seen[2], {3'h0, 2'h3, 8'hf0, 64'hffffffff_deadbeef}, "tx 32-bit");
            chk(mpf_mac_model_inst.seen[3], {3'h7, 2'h3, 8'hf0, 64'h0000abcd}, "tx upper lanes");
        end
        $display("test write done");
    endtask

    task automatic t_read;
        mpf_mac_model_inst.push(3'h3, 64'h0102030405060708, 8'h00, 1'b1, 1'b0, 1'b0);
        mpf_mac_model_inst.push(3'h3, 64'h00000000_00c0ffee, 8'hf8, 1'b0, 1'b1, 1'b0);
        mpf_mac_model_inst.push(3'h3, 64'h5a5a, 8'h00, 1'b0, 1'b0, 1'b1);
        idle(2);
        chk(data_oe, 1'b0, "bus driven without select");
        rd(3'h6, 1'b0, 1'b0, 64'h0, 8'hff, 1'b0, 1'b0);
        rd(3'h3, 1'b1, 1'b0, 64'h0102030405060708, 8'h00, 1'b1, 1'b0);
        rd(3'h3, 1'b0, 1'b0, 64'h0102030405060708, 8'h00, 1'b1, 1'b0);
        rd(3'h3, 1'b0, 1'b0, 64'h00c0ffee, 8'hf8, 1'b0, 1'b1);
        rd(3'h3, 1'b0, 1'b0, 64'h5a5a, 8'h00, 1'b0, 1'b0);
        rd(3'h3, 1'b0, 1'b0, 64'h0, 8'hff, 1'b0, 1'b0);
        $display("test read done");
    endtask

    task automatic t_abort;
        mpf_mac_model_inst.push(3'h2, 64'hc1, 8'h00, 1'b1, 1'b0, 1'b0);
        mpf_mac_model_inst.push(3'h2, 64'hc2, 8'h00, 1'b0, 1'b0, 1'b0);
        mpf_mac_model_inst.push(3'h2, 64'hc3, 8'hfe, 1'b0, 1'b1, 1'b0);
        mpf_mac_model_inst.push(3'h2, 64'h77, 8'h00, 1'b0, 1'b0, 1'b1);
        mpf_mac_model_inst.push(3'h2, 64'hf1, 8'hf0, 1'b1, 1'b0, 1'b0);
        rd(3'h2, 1'b0, 1'b0, 64'hc1, 8'h00, 1'b1, 1'b0);
        rd(3'h2, 1'b0, 1'b1, 64'h0, 8'hff, 1'b0, 1'b0);
        idle(8);
        rd(3'h2, 1'b0, 1'b0, 64'hf1, 8'hf0, 1'b1, 1'b0);
        $display("test abort done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        idle(2);
        chk({data_oe, tx_wr_ready, tx_valid}, 3'h2, "reset state");
        t_write();
        t_read();
        t_abort();
        chk(mpf_mac_model_inst.stuck, 0, "receive push never accepted");
        summarize();
    end
endmodule
